// File: rtl/jpi_irq_unit.v
`timescale 1ns/1ns
`include "jpi_defines.vh"
// interrupt enable and status block behind the byte register port
module jpi_irq_unit (
   clk_sys,
   rst,
   addr_load,
   addr_val,
   wr_stb,
   wr_data,
   rd_stb,
   rd_data,
   btn_press,
   btn_release,
   centre_dbl,
   turn_up,
   turn_down,
   at_upper,
   at_lower,
   gp_in,
   gp1_conf,
   gp2_conf,
   gp3_conf,
   ramp_done,
   ramp_running,
   int_out,
   int_oe
);
   input wire clk_sys;
   input wire rst;
   input wire addr_load;
   input wire [7:0] addr_val;
   input wire wr_stb;
   input wire [7:0] wr_data;
   input wire rd_stb;
   output reg [7:0] rd_data;
   // button order: 0 north, 1 south, 2 east, 3 west, 4 centre
   input wire [4:0] btn_press;
   input wire [4:0] btn_release;
   input wire centre_dbl;
   input wire turn_up;
   input wire turn_down;
   input wire at_upper;
   input wire at_lower;
   input wire [2:0] gp_in;
   input wire [7:0] gp1_conf;
   input wire [7:0] gp2_conf;
   input wire [7:0] gp3_conf;
   input wire ramp_done;
   input wire [2:0] ramp_running;
   output reg int_out;
   output reg int_oe;

   reg [15:0] interrupt_enable_reg;
   reg [15:0] interrupt_status_reg;
   reg [15:0] interrupt_status_next;
   reg [7:0] secondary_event_status_reg;
   reg [7:0] secondary_event_status_next;
   reg [7:0] ramp_progress_status_reg;
   reg [7:0] rd_mux;
   reg at_upper_reg;
   reg at_lower_reg;
   wire [7:0] ptr;
   wire [5:0] edge_codes;
   wire [15:0] main_evt;
   wire [7:0] sec_evt;
   wire rd_st_hi;
   wire rd_st_lo;
   wire rd_sec;

   // step after every read or write byte
   jpi_reg_ptr u_ptr (
      .clk_sys(clk_sys),
      .rst(rst),
      .ptr_load(addr_load),
      .ptr_load_val(addr_val),
      .ptr_step(wr_stb | rd_stb),
      .ptr(ptr)
   );

   // one edge detector per pin; conf bits 4:3 select edges, 1:0 the mode
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gp_edge
         wire [7:0] conf;
         assign conf = (g == 0) ? gp1_conf : (g == 1) ? gp2_conf : gp3_conf;
         jpi_edge_detect u_edge (
            .clk_sys(clk_sys),
            .rst(rst),
            .pin_in(gp_in[g]),
            .pin_mode(conf[1:0]),
            .edge_sel(conf[4:3]),
            .edge_code(edge_codes[2*g+1:2*g])
         );
      end
   endgenerate

   // limit flags fire on arrival at a limit, and once after reset if parked there, not while parked there later
   always @(posedge clk_sys) begin
      if (rst) begin
         at_upper_reg <= 1'b0;
         at_lower_reg <= 1'b0;
      end else begin
         at_upper_reg <= at_upper;
         at_lower_reg <= at_lower;
      end
   end

   // secondary events: pin fields, ramp bit, bit 7 never set
   assign sec_evt = {1'b0, ramp_done, edge_codes};

   // main events, lower byte matches enable layout
   assign main_evt = {
      |sec_evt,
      at_lower & ~at_lower_reg,
      at_upper & ~at_upper_reg,
      turn_down,
      turn_up,
      centre_dbl,
      btn_press[4], btn_release[4],
      btn_press[3], btn_release[3],
      btn_press[2], btn_release[2],
      btn_press[1], btn_release[1],
      btn_press[0], btn_release[0]
   };

   // read strobes of the clear-on-read registers
   assign rd_st_hi = rd_stb && (ptr == `JPI_ADDR_ST_HI);
   assign rd_st_lo = rd_stb && (ptr == `JPI_ADDR_ST_LO);
   assign rd_sec = rd_stb && (ptr == `JPI_ADDR_SEC);

   // read clears, a same-cycle event sets again so none is lost
   always @* begin
      interrupt_status_next = interrupt_status_reg;
      if (rd_st_hi) begin
         interrupt_status_next[15:8] = 8'h00;
      end
      if (rd_st_lo) begin
         interrupt_status_next[7:0] = 8'h00;
      end
      // flags set whatever the enables say
      interrupt_status_next = interrupt_status_next | main_evt;
      secondary_event_status_next = secondary_event_status_reg;
      if (rd_sec) begin
         secondary_event_status_next = 8'h00;
      end
      secondary_event_status_next = (secondary_event_status_next &
         8'h7f) | sec_evt;
   end

   // status registers and ramp progress mirror
   always @(posedge clk_sys) begin
      if (rst) begin
         interrupt_status_reg <= `JPI_ST_RESET;
         secondary_event_status_reg <= `JPI_SEC_RESET;
         ramp_progress_status_reg <= 8'h00;
      end else begin
         interrupt_status_reg <= interrupt_status_next;
         secondary_event_status_reg <= secondary_event_status_next;
         ramp_progress_status_reg <= {5'b0_0000, ramp_running};
      end
   end

   // enable register, host writable byte by byte
   always @(posedge clk_sys) begin
      if (rst) begin
         interrupt_enable_reg <= `JPI_EN_RESET;
      end else if (wr_stb && ptr == `JPI_ADDR_EN_HI) begin
         interrupt_enable_reg[15:8] <= wr_data;
      end else if (wr_stb && ptr == `JPI_ADDR_EN_LO) begin
         interrupt_enable_reg[7:0] <= wr_data;
      end
   end

   // open-drain line: drive low while something enabled is pending;
   // one enable bit per status flag gates the shared line, bit 15 for all secondary events
   always @(posedge clk_sys) begin
      if (rst) begin
         int_out <= 1'b1;
         int_oe <= 1'b0;
      end else begin
         int_out <= 1'b0;
         int_oe <= |(interrupt_status_next &
            interrupt_enable_reg);
      end
   end

   // read data; status registers are not host writable
   always @* begin
      case (ptr)
         `JPI_ADDR_EN_HI: rd_mux = interrupt_enable_reg[15:8];
         `JPI_ADDR_EN_LO: rd_mux = interrupt_enable_reg[7:0];
         `JPI_ADDR_ST_HI: rd_mux = interrupt_status_reg[15:8];
         `JPI_ADDR_ST_LO: rd_mux = interrupt_status_reg[7:0];
         `JPI_ADDR_SEC: rd_mux = secondary_event_status_reg;
         `JPI_ADDR_RAMP: rd_mux = ramp_progress_status_reg;
         default: rd_mux = 8'h00;
      endcase
   end

   // read byte registered on the strobe
   always @(posedge clk_sys) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_stb) begin
         rd_data <= rd_mux;
      end
   end
endmodule

// File: pkg/jpi_defines.vh
`ifndef JPI_DEFINES_VH
`define JPI_DEFINES_VH
`define JPI_ADDR_EN_HI 8'h04
`define JPI_ADDR_EN_LO 8'h05
`define JPI_ADDR_ST_HI 8'h06
`define JPI_ADDR_ST_LO 8'h07
`define JPI_ADDR_SEC 8'h08
`define JPI_ADDR_RAMP 8'h09
`define JPI_EN_RESET 16'h0000
`define JPI_ST_RESET 16'h0000
`define JPI_SEC_RESET 8'h00
`define JPI_BIT_SEC 15
`define JPI_BIT_LMIN 14
`define JPI_BIT_LMAX 13
`define JPI_BIT_DEC 12
`define JPI_BIT_INC 11
`define JPI_BIT_CDBL 10
`define JPI_BIT_CPRS 9
`define JPI_BIT_CREL 8
`define JPI_SEC_RAMP 6
`define JPI_EDGE_NONE 2'b00
`define JPI_EDGE_RISE 2'b01
`define JPI_EDGE_FALL 2'b10
`define JPI_EDGE_BOTH 2'b11
`define JPI_MODE_INPUT 2'b11
`endif

// File: rtl/jpi_edge_detect.v
`timescale 1ns/1ns
`include "jpi_defines.vh"
// edge event code for one general-purpose pin
module jpi_edge_detect (
   clk_sys,
   rst,
   pin_in,
   pin_mode,
   edge_sel,
   edge_code
);
   input wire clk_sys;
   input wire rst;
   input wire pin_in;
   input wire [1:0] pin_mode;
   input wire [1:0] edge_sel;
   output reg [1:0] edge_code;

   reg pin_last_reg;
   wire rise;
   wire fall;
   wire is_input;

   // previous sample for edge finding; reset loads the pin itself so a
   // pin idling high does not report a false rising edge after reset
   always @(posedge clk_sys) begin
      if (rst) begin
         pin_last_reg <= pin_in;
      end else begin
         pin_last_reg <= pin_in;
      end
   end

   assign is_input = (pin_mode == `JPI_MODE_INPUT);
   assign rise = pin_in & ~pin_last_reg;
   assign fall = ~pin_in & pin_last_reg;

   // code by selected edges, only in input mode
   always @* begin
      edge_code = `JPI_EDGE_NONE;
      if (is_input && rise && edge_sel[0]) begin
         edge_code = `JPI_EDGE_RISE;
      end else if (is_input && fall && edge_sel[1]) begin
         edge_code = `JPI_EDGE_FALL;
      end
   end
endmodule

// File: rtl/jpi_reg_ptr.v
`timescale 1ns/1ns
// register address pointer with auto increment
module jpi_reg_ptr (
   clk_sys,
   rst,
   ptr_load,
   ptr_load_val,
   ptr_step,
   ptr
);
   input wire clk_sys;
   input wire rst;
   input wire ptr_load;
   input wire [7:0] ptr_load_val;
   input wire ptr_step;
   output reg [7:0] ptr;

   // load wins; a step follows every byte access
   always @(posedge clk_sys) begin
      if (rst) begin
         ptr <= 8'h00;
      end else if (ptr_load) begin
         ptr <= ptr_load_val;
      end else if (ptr_step) begin
         ptr <= ptr + 8'h01;
      end
   end
endmodule

// File: verif/jpi_irq_monitor.sv
`timescale 1ns/1ns
// watches the byte register port and the interrupt pin
module jpi_irq_monitor (
   input wire clk_sys,
   input wire rst,
   input wire addr_load,
   input wire [7:0] addr_val,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] rd_data,
   input wire [2:0] ramp_running,
   input wire int_out,
   input wire int_oe
);
   reg [7:0] ptr_reg;
   wire acc = rd_stb | wr_stb;
   wire rd_go = rd_stb & ~addr_load;
   // shadow pointer, a load beats a step
   always @(posedge clk_sys) begin
      if (rst)
         ptr_reg <= 8'h00;
      else if (addr_load)
         ptr_reg <= addr_val;
      else if (acc)
         ptr_reg <= ptr_reg + 8'h01;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_pin_low: assert property (!$past(rst) |-> !int_out)
      else $error("int_out not low");
   a_oe_reset: assert property ($past(rst) |-> !int_oe)
      else $error("int_oe set after reset");
   // only a read or an enable write may release the line
   a_oe_fall: assert property ($fell(int_oe) |->
      ($past(acc) || $past(acc, 2) || $past(acc, 3)))
      else $error("int_oe fell without access");
   a_oe_hold: assert property ((!acc [*3]) ##0 int_oe |=> int_oe)
      else $error("int_oe dropped while idle");
   a_rd_hold: assert property (!rd_stb |=> $stable(rd_data))
      else $error("rd_data moved without read");
   a_unmapped_zero: assert property (rd_go &&
      (ptr_reg < 8'h04 || ptr_reg > 8'h09) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_ramp_read: assert property (rd_go && ptr_reg == 8'h09 |=>
      rd_data == {5'h00, $past(ramp_running, 2)})
      else $error("ramp progress wrong");
   a_sec_top: assert property (rd_go && ptr_reg == 8'h08 |=> !rd_data[7])
      else $error("secondary bit 7 set");
endmodule

// File: verif/jpi_host_model.sv
`timescale 1ns/1ns
// bus master side: loads the pointer, then bursts bytes
module jpi_host_model (
   input wire clk_sys,
   output logic addr_load = 1'b0,
   output logic [7:0] addr_val = 8'h00,
   output logic wr_stb = 1'b0,
   output logic [7:0] wr_data = 8'h00,
   output logic rd_stb = 1'b0,
   input wire [7:0] rd_data
);
   task ld(input logic [7:0] a);
      @(negedge clk_sys);
      addr_load = 1'b1;
      addr_val = a;
   endtask
   // bursts lean on the pointer stepping; idle lines keep toggling
   task wr(input logic [7:0] a, input int n, input logic [15:0] d);
      ld(a);
      repeat (n) begin
         @(negedge clk_sys);
         addr_load = 1'b0;
         addr_val = ~addr_val;
         wr_stb = 1'b1;
         wr_data = d[15:8];
         d = d << 8;
      end
      @(negedge clk_sys);
      wr_stb = 1'b0;
      wr_data = ~wr_data;
   endtask
   task rd(input logic [7:0] a, input int n, output logic [15:0] d);
      ld(a);
      d = 16'h0000;
      repeat (n) begin
         @(negedge clk_sys);
         addr_load = 1'b0;
         addr_val = ~addr_val;
         if (rd_stb)
            d = {d[7:0], rd_data};
         rd_stb = 1'b1;
      end
      @(negedge clk_sys);
      d = {d[7:0], rd_data};
      rd_stb = 1'b0;
   endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ns
module tb;
   logic clk_sys, rst, addr_load, wr_stb, rd_stb, int_out, int_oe;
   logic [7:0] addr_val, wr_data, rd_data, gp1_conf, gp2_conf, gp3_conf;
   logic [15:0] ev_v, st;
   logic [2:0] gp_in, ramp_running;
   logic [20:0] rows [0:29];
   int n_errors = 0, compares = 0, cyc = 0, src;
   jpi_host_model i_host (.clk_sys(clk_sys), .addr_load(addr_load),
      .addr_val(addr_val), .wr_stb(wr_stb), .wr_data(wr_data),
      .rd_stb(rd_stb), .rd_data(rd_data));
   // event vector bits follow the status layout, bit 15 is the ramp event
   jpi_irq_unit i_dut (.clk_sys(clk_sys), .rst(rst),
      .addr_load(addr_load), .addr_val(addr_val), .wr_stb(wr_stb),
      .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
      .btn_press({ev_v[9], ev_v[7], ev_v[5], ev_v[3], ev_v[1]}),
      .btn_release({ev_v[8], ev_v[6], ev_v[4], ev_v[2], ev_v[0]}),
      .centre_dbl(ev_v[10]), .turn_up(ev_v[11]), .turn_down(ev_v[12]),
      .at_upper(ev_v[13]), .at_lower(ev_v[14]), .gp_in(gp_in),
      .gp1_conf(gp1_conf), .gp2_conf(gp2_conf), .gp3_conf(gp3_conf),
      .ramp_done(ev_v[15]), .ramp_running(ramp_running),
      .int_out(int_out), .int_oe(int_oe));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   // interrupt pin pair: data stays low, enable carries the request
   task chk_irq(input logic exp);
      compares++;
      if ({int_out, int_oe} !== {1'b0, exp}) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time,
            {int_out, int_oe}, {1'b0, exp});
      end
   endtask
   task ev(input int i);
      @(negedge clk_sys);
      ev_v = 16'h0001 << i;
      @(negedge clk_sys);
      ev_v = 16'h0000;
   endtask
   task complete_run;
      $display("n_errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard, the run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         complete_run;
      end
   end
   initial begin
      rst = 1'b1;
      ev_v = 16'h0000;
      gp_in = 3'h0;
      ramp_running = 3'h0;
      gp1_conf = 8'h1b;
      gp2_conf = 8'h0b;
      gp3_conf = 8'h13;
      for (int i = 0; i < 15; i++) begin
         rows[2 * i] = {5'(i), 16'h0001 << i};
         rows[2 * i + 1] = {5'(i), ~(16'h0001 << i)};
      end
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      i_host.rd(8'h04, 2, st);
      chk(st, 16'h0000);
      i_host.wr(8'h04, 2, 16'ha5c3);
      i_host.rd(8'h04, 2, st);
      chk(st, 16'ha5c3);
      // writes to the status area must be dropped
      i_host.wr(8'h06, 4, 16'hffff);
      ramp_running = 3'h5;
      i_host.rd(8'h06, 2, st);
      chk(st, 16'h0000);
      i_host.rd(8'h08, 2, st);
      chk(st, 16'h0005);
      i_host.rd(8'h30, 1, st);
      chk(st, 16'h0000);
      ramp_running = 3'h0;
      // sources 0 to 14 alone, enabled and then masked
      foreach (rows[r]) begin
         src = rows[r][20:16];
         i_host.wr(8'h04, 2, rows[r][15:0]);
         ev(src);
         repeat (2) @(negedge clk_sys);
         chk_irq(rows[r][src]);
         i_host.rd(8'h06, 2, st);
         chk(st, 16'h0001 << src);
         @(negedge clk_sys);
         chk_irq(1'b0);
         i_host.rd(8'h06, 2, st);
         chk(st, 16'h0000);
      end
      // pin 1 both edges, pin 2 rising, pin 3 falling
      i_host.wr(8'h04, 2, 16'h8000);
      gp_in = 3'h7;
      repeat (4) @(negedge clk_sys);
      chk_irq(1'b1);
      i_host.rd(8'h08, 1, st);
      chk(st, 16'h0005);
      gp_in = 3'h0;
      repeat (4) @(negedge clk_sys);
      i_host.rd(8'h08, 1, st);
      chk(st, 16'h0022);
      ev(15);
      i_host.rd(8'h08, 2, st);
      chk(st, 16'h4000);
      i_host.rd(8'h06, 2, st);
      chk(st, 16'h8000);
      // pin 1 out of input mode ignores its edges
      gp1_conf = 8'h18;
      gp_in = 3'h1;
      repeat (4) @(negedge clk_sys);
      i_host.rd(8'h08, 1, st);
      chk(st, 16'h0000);
      // mid-run reset drops a pending request; a high pin gives no edge
      gp1_conf = 8'h1b;
      i_host.wr(8'h04, 2, 16'h0200);
      ev(9);
      chk_irq(1'b1);
      rst = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      chk_irq(1'b0);
      i_host.rd(8'h04, 2, st);
      chk(st, 16'h0000);
      i_host.rd(8'h06, 2, st);
      chk(st, 16'h0000);
      i_host.rd(8'h08, 1, st);
      chk(st, 16'h0000);
      complete_run;
   end
endmodule
bind jpi_irq_unit jpi_irq_monitor i_mon (.clk_sys(clk_sys), .rst(rst),
   .addr_load(addr_load), .addr_val(addr_val), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rd_data(rd_data), .ramp_running(ramp_running),
   .int_out(int_out), .int_oe(int_oe));
